/* verilog/rxdiag_pkg.sv */
package rxdiag_pkg;

  // ****************************************************************
  // Test output and analog route selections
  // ****************************************************************
  localparam logic [1:0] TCOMB_OFF     = 2'h0;
  localparam logic [1:0] TCOMB_IQ      = 2'h1;
  localparam logic [1:0] TCOMB_TXRX    = 2'h2;
  localparam logic [1:0] TCOMB_RXEN    = 2'h3;
  localparam logic [1:0] ANAOUT_OFF    = 2'h0;
  localparam logic [1:0] ANAOUT_IQ     = 2'h1;
  localparam logic [1:0] ANAOUT_MIXDC  = 2'h2;

  // ****************************************************************
  // Readout pages
  // ****************************************************************
  localparam logic [3:0] RSSI_PAGE_LOG = 4'h6;
  localparam logic [1:0] CONV_PAGE_ADC = 2'h0;

  // ****************************************************************
  // Converter sources
  // ****************************************************************
  localparam logic [3:0] MSEL_MIX_I    = 4'h1;
  localparam logic [3:0] MSEL_MIX_Q    = 4'h2;
  localparam logic [3:0] MSEL_EXT_DET  = 4'h3;
  localparam logic [3:0] MSEL_OSC_LVL  = 4'h4;
  localparam logic [3:0] MSEL_VEXT     = 4'h7;
  localparam logic [3:0] MSEL_VDD_B    = 4'h8;
  localparam logic [3:0] MSEL_VEXT_PA  = 4'h9;
  localparam logic [3:0] MSEL_VDD_PA   = 4'hA;
  localparam logic [3:0] MSEL_LIN_I    = 4'hB;
  localparam logic [3:0] MSEL_LIN_Q    = 4'hC;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS  = 8;
  localparam int CONV_TIME_NS   = 20000;
  localparam int CONV_CYCLES    = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam logic [7:0] RESULT_RESET = 8'h00;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic [7:0] pilot;
    logic [7:0] data;
    logic [7:0] peak;
  } rxdiag_rssi_s;

  typedef struct packed {
    logic [11:0] first_cross;
    logic [11:0] cross_len;
    logic [11:0] first_viol;
  } rxdiag_time_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_DONE = 3'b100
  } rxdiag_conv_e;

endpackage

/* verilog/rxdiag_ctrl.sv */
`timescale 1ns/1ns
module rxdiag_ctrl #(
  parameter int CONV_CYC = rxdiag_pkg::CONV_CYCLES
) (
  input  wire logic                       SYS_CLK,
  input  wire logic                       RST_B,
  input  wire logic [1:0]                 TEST_COMB,
  input  wire logic [1:0]                 ANALOG_OUT_SEL,
  input  wire logic                       DIRECT_MODE,
  input  wire logic                       DIRECT_OUT_SEL,
  input  wire logic [3:0]                 RSSI_READOUT_PAGE,
  input  wire logic [1:0]                 CONVERTER_READOUT_PAGE,
  input  wire logic [3:0]                 MEAS_SOURCE,
  input  wire logic [3:0]                 COLLISION_THRESHOLD,
  input  wire logic                       CMD_CONVERT,
  input  wire logic                       CMD_MON_ENABLE,
  input  wire logic                       CMD_MON_DISABLE,
  input  wire logic                       RX_ENABLE_PIN,
  input  wire logic                       RX_ACTIVE,
  input  wire logic                       TX_START,
  input  wire logic                       RX_SECOND_BYTE,
  input  wire logic                       RX_BIT_STROBE,
  input  wire logic                       RX_PILOT_END,
  input  wire logic                       RX_DATA_START,
  input  wire logic                       RX_END,
  input  wire logic                       RX_PROTO_ERROR,
  input  wire logic                       DIG_I,
  input  wire logic                       DIG_Q,
  input  wire logic                       TX_MOD,
  input  wire logic                       RX_SEL_Q,
  input  wire logic                       DEC_DATA,
  input  wire logic                       DEC_CLK,
  input  wire logic [3:0]                 RSSI_ENV,
  input  wire logic [3:0]                 LOG_RSSI_I,
  input  wire logic [3:0]                 LOG_RSSI_Q,
  input  wire logic [7:0]                 SAMPLE_IN,
  input  wire logic [7:0]                 LIN_MIN,
  input  wire logic [7:0]                 LIN_MAX,
  input  wire logic                       PHASE_IN,
  output logic [1:0]                      DIG_TEST_OUT,
  output logic [1:0]                      ANALOG_TEST_ROUTE,
  output logic                            TEST_OUT_DRIVE_DIGITAL,
  output logic                            CONV_PIN_OUT,
  output logic                            CONV_PIN_OE,
  output logic                            DATA_OUT_PIN,
  output logic                            IRQ_PIN,
  output logic                            RX_START,
  output logic [3:0]                      SAMPLE_SEL,
  output logic                            SAMPLE_HOLD,
  output logic [7:0]                      CONV_RESULT,
  output logic                            CONV_BUSY,
  output logic                            CMD_DONE_IRQ,
  output logic [7:0]                      RSSI_READOUT,
  output logic                            PHASE_STATUS,
  output logic                            PHASE_VALID,
  output logic                            MON_ENABLED,
  output logic                            COLLISION_FLAG,
  output rxdiag_pkg::rxdiag_rssi_s        MON_RSSI,
  output rxdiag_pkg::rxdiag_time_s        MON_TIME
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [1:0] rxen_sync_q;
  logic       rxen_prev_q;

  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      rxen_sync_q <= 2'h0;
      rxen_prev_q <= 1'b0;
    end else begin
      rxen_sync_q <= {rxen_sync_q[0], RX_ENABLE_PIN};
      rxen_prev_q <= rxen_sync_q[1];
    end
  end

  // ****************************************************************
  // Test output and direct mode routing
  // ****************************************************************
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      DIG_TEST_OUT           <= 2'h0;
      ANALOG_TEST_ROUTE      <= 2'h0;
      TEST_OUT_DRIVE_DIGITAL <= 1'b0;
      CONV_PIN_OUT           <= 1'b0;
      CONV_PIN_OE            <= 1'b0;
      DATA_OUT_PIN           <= 1'b0;
      IRQ_PIN                <= 1'b0;
      RX_START               <= 1'b0;
    end else begin
      DIG_TEST_OUT           <= 2'h0;
      TEST_OUT_DRIVE_DIGITAL <= 1'b0;
      ANALOG_TEST_ROUTE      <= ANALOG_OUT_SEL;
      unique case (TEST_COMB)
        rxdiag_pkg::TCOMB_IQ: begin
          DIG_TEST_OUT           <= {DIG_Q, DIG_I};
          TEST_OUT_DRIVE_DIGITAL <= 1'b1;
          ANALOG_TEST_ROUTE      <= rxdiag_pkg::ANAOUT_OFF;
        end
        rxdiag_pkg::TCOMB_TXRX: begin
          DIG_TEST_OUT           <= {(RX_SEL_Q ? DIG_Q : DIG_I), TX_MOD};
          TEST_OUT_DRIVE_DIGITAL <= 1'b1;
          ANALOG_TEST_ROUTE      <= rxdiag_pkg::ANAOUT_OFF;
        end
        default: begin
        end
      endcase
      // Analog field 01 gives I/Q, 10 gives mixer DC levels; the analog switch uses it unless TCOMB_IQ or TCOMB_TXRX forces ANAOUT_OFF.
      CONV_PIN_OE  <= (TEST_COMB == rxdiag_pkg::TCOMB_RXEN);
      CONV_PIN_OUT <= (TEST_COMB == rxdiag_pkg::TCOMB_RXEN) && RX_ACTIVE;
      RX_START     <= DIRECT_MODE && rxen_sync_q[1] && !rxen_prev_q;
      if (DIRECT_MODE && !DIRECT_OUT_SEL) begin
        DATA_OUT_PIN <= DEC_DATA;
        IRQ_PIN      <= DEC_CLK;
      end else if (DIRECT_MODE) begin
        DATA_OUT_PIN <= DIG_I;
        IRQ_PIN      <= DIG_Q;
      end else begin
        DATA_OUT_PIN <= 1'b0;
        IRQ_PIN      <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Converter
  // ****************************************************************
  rxdiag_pkg::rxdiag_conv_e state_q;
  logic [15:0]              conv_cnt_q;
  logic                     lin_src;

  // Linear samples span LIN_MIN..LIN_MAX and are stretched to +-127.
  function automatic logic [7:0] to_sign_mag(input logic [7:0] v, input logic lin,
                                             input logic [7:0] lo, input logic [7:0] hi);
    logic [16:0] num;
    logic [8:0]  span;
    logic [8:0]  scaled;
    num    = 17'h0_0000;
    span   = 9'h000;
    scaled = 9'h000;
    if (lin) begin
      span = (hi > lo) ? {1'b0, hi - lo} : 9'h001;
      num  = (v > lo) ? {9'h000, v - lo} * 17'h0_00FE : 17'h0_0000;
      scaled = (v >= hi) ? 9'h0FE : 9'(num / {8'h00, span});
      return (scaled >= 9'h07F) ? {1'b1, 7'(scaled - 9'h07F)}
                                : {1'b0, 7'(9'h07F - scaled)};
    end
    return v[7] ? {1'b1, v[6:0]} : {1'b0, 7'(~v[6:0] + 7'h01)};
  endfunction

  assign lin_src    = (MEAS_SOURCE == rxdiag_pkg::MSEL_LIN_I) ||
                      (MEAS_SOURCE == rxdiag_pkg::MSEL_LIN_Q);
  assign SAMPLE_SEL = MEAS_SOURCE;
  assign CONV_BUSY  = (state_q == rxdiag_pkg::ST_CONV);

  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      state_q      <= rxdiag_pkg::ST_IDLE;
      conv_cnt_q   <= 16'h0000;
      CONV_RESULT  <= rxdiag_pkg::RESULT_RESET;
      CMD_DONE_IRQ <= 1'b0;
    end else begin
      CMD_DONE_IRQ <= 1'b0;
      if (CMD_CONVERT) begin
        state_q    <= rxdiag_pkg::ST_CONV;
        conv_cnt_q <= 16'h0000;
      end else begin
        unique case (state_q)
          rxdiag_pkg::ST_CONV: begin
            conv_cnt_q <= conv_cnt_q + 16'h0001;
            if (conv_cnt_q == 16'(CONV_CYC - 1)) begin
              state_q     <= rxdiag_pkg::ST_DONE;
              CONV_RESULT <= to_sign_mag(SAMPLE_IN, lin_src, LIN_MIN, LIN_MAX);
            end
          end
          rxdiag_pkg::ST_DONE: begin
            CMD_DONE_IRQ <= 1'b1;
            state_q      <= rxdiag_pkg::ST_IDLE;
          end
          default: state_q <= rxdiag_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // ****************************************************************
  // Logarithmic RSSI and phase bit
  // ****************************************************************
  logic [7:0] log_rssi_q;

  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      log_rssi_q   <= 8'h00;
      PHASE_STATUS <= 1'b0;
      PHASE_VALID  <= 1'b0;
      SAMPLE_HOLD  <= 1'b0;
    end else begin
      if (TX_START) begin
        log_rssi_q <= 8'h00;
      end else if (RX_SECOND_BYTE) begin
        log_rssi_q <= {LOG_RSSI_Q, LOG_RSSI_I};
      end
      SAMPLE_HOLD <= RX_PILOT_END;
      if (RX_PILOT_END) begin
        PHASE_STATUS <= PHASE_IN;
        PHASE_VALID  <= 1'b1;
      end else if (RX_END) begin
        PHASE_VALID  <= 1'b0;
      end
    end
  end

  // The page compare lets other pages read zero, since they belong elsewhere.
  assign RSSI_READOUT = (RSSI_READOUT_PAGE == rxdiag_pkg::RSSI_PAGE_LOG) ? log_rssi_q
                                                                       : 8'h00;

  // ****************************************************************
  // Interrogator collision monitor
  // ****************************************************************
  logic [11:0] bit_cnt_q;
  logic        above;
  logic        crossed_q;
  logic        viol_seen_q;
  logic        in_pkt_q;

  assign above = RSSI_ENV > COLLISION_THRESHOLD;

  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      MON_ENABLED <= 1'b0;
    end else if (CMD_MON_DISABLE) begin
      MON_ENABLED <= 1'b0;
    end else if (CMD_MON_ENABLE) begin
      MON_ENABLED <= 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_B || CMD_MON_DISABLE) begin
      COLLISION_FLAG <= 1'b0;
      MON_RSSI       <= '0;
      MON_TIME       <= '0;
      bit_cnt_q      <= 12'h000;
      crossed_q      <= 1'b0;
      viol_seen_q    <= 1'b0;
      in_pkt_q       <= 1'b0;
    end else if (MON_ENABLED) begin
      if (TX_START) begin
        in_pkt_q    <= 1'b1;
        bit_cnt_q   <= 12'h000;
        crossed_q   <= 1'b0;
        viol_seen_q <= 1'b0;
      end else if (RX_END) begin
        in_pkt_q <= 1'b0;
      end
      if (in_pkt_q && RX_BIT_STROBE) begin
        bit_cnt_q <= bit_cnt_q + 12'h001;
        if (above) begin
          COLLISION_FLAG <= 1'b1;
          MON_TIME.cross_len <= MON_TIME.cross_len + 12'h001;
          if (!crossed_q) begin
            crossed_q <= 1'b1;
            MON_TIME.first_cross <= bit_cnt_q;
          end
        end
      end
      if (in_pkt_q && RX_PROTO_ERROR && !viol_seen_q) begin
        viol_seen_q <= 1'b1;
        MON_TIME.first_viol <= bit_cnt_q;
      end
      if (in_pkt_q && RX_PILOT_END) begin
        MON_RSSI.pilot <= {4'h0, RSSI_ENV};
      end
      if (in_pkt_q && RX_DATA_START) begin
        MON_RSSI.data <= {4'h0, RSSI_ENV};
      end
      if (in_pkt_q && ({4'h0, RSSI_ENV} > MON_RSSI.peak)) begin
        MON_RSSI.peak <= {4'h0, RSSI_ENV};
      end
    end
  end

endmodule

/* testbench/rxdiag_ctrl_props.sv */
`timescale 1ns/1ns
module rxdiag_ctrl_props #(
  parameter int CONV_CYC = rxdiag_pkg::CONV_CYCLES
) (
  input logic                       SYS_CLK,
  input logic                       RST_B,
  input logic [1:0]                 TEST_COMB,
  input logic [1:0]                 ANALOG_OUT_SEL,
  input logic                       DIRECT_MODE,
  input logic                       DIRECT_OUT_SEL,
  input logic [3:0]                 RSSI_READOUT_PAGE,
  input logic                       CMD_CONVERT,
  input logic                       CMD_MON_DISABLE,
  input logic                       RX_ENABLE_PIN,
  input logic                       DIG_I,
  input logic                       DIG_Q,
  input logic                       TX_MOD,
  input logic                       RX_SEL_Q,
  input logic [1:0]                 DIG_TEST_OUT,
  input logic [1:0]                 ANALOG_TEST_ROUTE,
  input logic                       DATA_OUT_PIN,
  input logic                       IRQ_PIN,
  input logic                       RX_START,
  input logic [7:0]                 CONV_RESULT,
  input logic                       CONV_BUSY,
  input logic                       CMD_DONE_IRQ,
  input logic [7:0]                 RSSI_READOUT,
  input logic                       MON_ENABLED,
  input rxdiag_pkg::rxdiag_rssi_s   MON_RSSI,
  input rxdiag_pkg::rxdiag_time_s   MON_TIME
);
  // ****************************************************************
  // Conversion age counter
  // ****************************************************************
  // A retrigger restarts the age, so a stale count can never excuse a late done pulse.
  int cnt_q;
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) cnt_q <= 0;
    else if (CMD_CONVERT) cnt_q <= 1;
    else if (cnt_q != 0 && cnt_q < 100000) cnt_q <= cnt_q + 1;
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  tcomb_iq_a: assert property (TEST_COMB == rxdiag_pkg::TCOMB_IQ && !DIRECT_MODE |=>
    DIG_TEST_OUT == {$past(DIG_Q), $past(DIG_I)}) else $error("iq test outputs wrong");
  tcomb_txrx_a: assert property (TEST_COMB == rxdiag_pkg::TCOMB_TXRX && !DIRECT_MODE |=>
    DIG_TEST_OUT == {$past(RX_SEL_Q) ? $past(DIG_Q) : $past(DIG_I), $past(TX_MOD)})
    else $error("tx rx test outputs wrong");
  ana_prio_a: assert property (TEST_COMB[0] != TEST_COMB[1] |=>
    ANALOG_TEST_ROUTE == 2'h0) else $error("analog route not suppressed");
  ana_route_a: assert property (TEST_COMB[0] == TEST_COMB[1] |=>
    ANALOG_TEST_ROUTE == $past(ANALOG_OUT_SEL)) else $error("analog route wrong");
  raw_iq_a: assert property (DIRECT_MODE && DIRECT_OUT_SEL |=>
    {DATA_OUT_PIN, IRQ_PIN} == {$past(DIG_I), $past(DIG_Q)}) else $error("raw iq wrong");
  rx_start_a: assert property ($rose(RX_ENABLE_PIN) && DIRECT_MODE |-> ##[2:4] RX_START)
    else $error("reception did not start");
  conv_busy_a: assert property (CMD_CONVERT |=> CONV_BUSY) else $error("no busy");
  done_time_a: assert property (CMD_DONE_IRQ |-> cnt_q inside {[CONV_CYC+1:CONV_CYC+2]})
    else $error("done pulse off time");
  result_hold_a: assert property ($changed(CONV_RESULT) |=> CMD_DONE_IRQ)
    else $error("result moved without done");
  page_mask_a: assert property (RSSI_READOUT_PAGE != rxdiag_pkg::RSSI_PAGE_LOG |->
    RSSI_READOUT == 8'h00) else $error("rssi shown on wrong page");
  mon_clear_a: assert property (CMD_MON_DISABLE |=> !MON_ENABLED && MON_RSSI == '0 &&
    MON_TIME == '0) else $error("monitor not cleared");
  cover property (CMD_DONE_IRQ);
  cover property (CMD_MON_DISABLE && MON_ENABLED);
  cover property ($rose(RX_START));
endmodule
bind rxdiag_ctrl rxdiag_ctrl_props #(.CONV_CYC(CONV_CYC)) u_props (.*);

/* testbench/rxdiag_host_model.sv */
`timescale 1ns/1ns
module rxdiag_host_model (
  input  wire logic       SYS_CLK,
  input  wire logic       CMD_DONE_IRQ,
  input  wire logic [7:0] CONV_RESULT,
  output logic            CMD_CONVERT,
  output logic            CMD_MON_ENABLE,
  output logic            CMD_MON_DISABLE
);
  initial {CMD_CONVERT, CMD_MON_ENABLE, CMD_MON_DISABLE} = 3'h0;
  // Kind 0 triggers a conversion, 1 enables and 2 disables the monitor.
  task automatic command(input int kind);
    @(negedge SYS_CLK);
    CMD_CONVERT = (kind == 0);
    CMD_MON_ENABLE = (kind == 1);
    CMD_MON_DISABLE = (kind == 2);
    @(negedge SYS_CLK);
    {CMD_CONVERT, CMD_MON_ENABLE, CMD_MON_DISABLE} = 3'h0;
  endtask
  task automatic await_done(input int lim, output logic [7:0] res, output bit ok);
    ok = 0;
    res = 8'h00;
    for (int i = 0; i < lim && !ok; i++) begin
      @(posedge SYS_CLK);
      #1;
      if (CMD_DONE_IRQ === 1'b1) begin
        ok = 1;
        res = CONV_RESULT;
      end
    end
  endtask
endmodule

/* testbench/rxdiag_ctrl_tb_top.sv */
`timescale 1ns/1ns
module rxdiag_ctrl_tb_top;
  localparam int CYC = 10;
  logic SYS_CLK = 0, RST_B = 0;
  logic [1:0] TEST_COMB, ANALOG_OUT_SEL, CONVERTER_READOUT_PAGE, DIG_TEST_OUT, ANALOG_TEST_ROUTE;
  logic [3:0] RSSI_READOUT_PAGE, MEAS_SOURCE, COLLISION_THRESHOLD, RSSI_ENV, SAMPLE_SEL;
  logic [3:0] LOG_RSSI_I, LOG_RSSI_Q;
  logic [7:0] SAMPLE_IN, LIN_MIN, LIN_MAX, CONV_RESULT, RSSI_READOUT;
  logic DIRECT_MODE, DIRECT_OUT_SEL, CMD_CONVERT, CMD_MON_ENABLE, CMD_MON_DISABLE, RX_ENABLE_PIN;
  logic RX_ACTIVE, TX_START, RX_SECOND_BYTE, RX_BIT_STROBE, RX_PILOT_END, RX_DATA_START, RX_END;
  logic RX_PROTO_ERROR, DIG_I, DIG_Q, TX_MOD, RX_SEL_Q, DEC_DATA, DEC_CLK, PHASE_IN;
  logic TEST_OUT_DRIVE_DIGITAL, CONV_PIN_OUT, CONV_PIN_OE, DATA_OUT_PIN, IRQ_PIN, RX_START;
  logic SAMPLE_HOLD, CONV_BUSY, CMD_DONE_IRQ, PHASE_STATUS, PHASE_VALID, MON_ENABLED;
  logic COLLISION_FLAG;
  rxdiag_pkg::rxdiag_rssi_s MON_RSSI;
  rxdiag_pkg::rxdiag_time_s MON_TIME;
  int error_cnt = 0, compares = 0;
  logic [3:0] srcs [8] = '{rxdiag_pkg::MSEL_MIX_I, rxdiag_pkg::MSEL_MIX_Q,
    rxdiag_pkg::MSEL_EXT_DET, rxdiag_pkg::MSEL_OSC_LVL, rxdiag_pkg::MSEL_VEXT,
    rxdiag_pkg::MSEL_VDD_B, rxdiag_pkg::MSEL_VEXT_PA, rxdiag_pkg::MSEL_VDD_PA};
  always #4 SYS_CLK = ~SYS_CLK;
  rxdiag_ctrl #(.CONV_CYC(CYC)) u_dut (.*);
  rxdiag_host_model u_host (.*);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("TB: compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge SYS_CLK);
  endtask
  task automatic pulse(ref logic s);
    @(negedge SYS_CLK);
    s = 1;
    @(negedge SYS_CLK);
    s = 0;
  endtask
  // Offset-binary samples around 8'h80 come back as sign and magnitude.
  task automatic conv(input logic [3:0] src, input logic [7:0] smp, input logic [7:0] exp);
    logic [7:0] res;
    bit ok;
    @(negedge SYS_CLK);
    MEAS_SOURCE = src;
    SAMPLE_IN = smp;
    u_host.command(0);
    check(CONV_BUSY, 1'b1);
    u_host.await_done(CYC + 3, res, ok);
    check(ok, 1'b1);
    if (!ok) conclude();
    check(CONV_BUSY, 1'b0);
    check(res, exp);
    check(SAMPLE_SEL, src);
  endtask
  initial begin
    #400000;
    error_cnt++;
    conclude();
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {TEST_COMB, ANALOG_OUT_SEL, CONVERTER_READOUT_PAGE, RSSI_READOUT_PAGE, MEAS_SOURCE} = '0;
    {COLLISION_THRESHOLD, RSSI_ENV, LOG_RSSI_I, LOG_RSSI_Q, SAMPLE_IN, LIN_MIN, LIN_MAX} = '0;
    {DIRECT_MODE, DIRECT_OUT_SEL, RX_ENABLE_PIN, RX_ACTIVE, TX_START, RX_SECOND_BYTE} = '0;
    {RX_BIT_STROBE, RX_PILOT_END, RX_DATA_START, RX_END, RX_PROTO_ERROR, PHASE_IN} = '0;
    {DIG_I, DIG_Q, TX_MOD, RX_SEL_Q, DEC_DATA, DEC_CLK} = '0;
    step(16);
    RST_B = 1;
    step(1);
    check(CONV_RESULT, rxdiag_pkg::RESULT_RESET);
    ANALOG_OUT_SEL = rxdiag_pkg::ANAOUT_IQ;
    {DIG_I, DIG_Q, TX_MOD, RX_SEL_Q, RX_ACTIVE} = 5'h13;
    TEST_COMB = rxdiag_pkg::TCOMB_IQ;
    step(1);
    check(DIG_TEST_OUT, 2'h1);
    check(ANALOG_TEST_ROUTE, 2'h0);
    check(TEST_OUT_DRIVE_DIGITAL, 1'b1);
    TEST_COMB = rxdiag_pkg::TCOMB_TXRX;
    step(1);
    check(DIG_TEST_OUT, 2'h0);
    RX_SEL_Q = 0;
    step(1);
    check(DIG_TEST_OUT, 2'h2);
    TEST_COMB = rxdiag_pkg::TCOMB_RXEN;
    step(1);
    check({CONV_PIN_OE, CONV_PIN_OUT}, 2'h3);
    TEST_COMB = rxdiag_pkg::TCOMB_OFF;
    step(1);
    check(ANALOG_TEST_ROUTE, rxdiag_pkg::ANAOUT_IQ);
    check(TEST_OUT_DRIVE_DIGITAL, 1'b0);
    ANALOG_OUT_SEL = rxdiag_pkg::ANAOUT_MIXDC;
    step(1);
    check(ANALOG_TEST_ROUTE, rxdiag_pkg::ANAOUT_MIXDC);
    $display("TB: routing test done");
    {DIRECT_MODE, DIRECT_OUT_SEL, DEC_DATA, DEC_CLK} = 4'h9;
    step(1);
    check({DATA_OUT_PIN, IRQ_PIN}, 2'h1);
    DIRECT_OUT_SEL = 1;
    step(1);
    check({DATA_OUT_PIN, IRQ_PIN}, 2'h2);
    RX_ENABLE_PIN = 1;
    step(3);
    check(RX_START, 1'b1);
    step(1);
    check(RX_START, 1'b0);
    step(2);
    DIRECT_MODE = 0;
    $display("TB: direct mode test done");
    for (int i = 0; i < 8; i++) conv(srcs[i], i[0] ? 8'h85 : 8'h7B, i[0] ? 8'h85 : 8'h05);
    {LIN_MIN, LIN_MAX, SAMPLE_IN} = 24'h20E0_20;
    PHASE_IN = 1;
    pulse(RX_PILOT_END);
    check(SAMPLE_HOLD, 1'b1);
    check({PHASE_VALID, PHASE_STATUS}, 2'h3);
    conv(rxdiag_pkg::MSEL_LIN_I, 8'h20, 8'h7F);
    SAMPLE_IN = 8'hE0;
    pulse(RX_PILOT_END);
    conv(rxdiag_pkg::MSEL_LIN_Q, 8'hE0, 8'hFF);
    SAMPLE_IN = 8'h33;
    step(4);
    check(CONV_RESULT, 8'hFF);
    pulse(RX_END);
    check(PHASE_VALID, 1'b0);
    $display("TB: converter test done");
    RSSI_READOUT_PAGE = rxdiag_pkg::RSSI_PAGE_LOG;
    {LOG_RSSI_Q, LOG_RSSI_I} = 8'h95;
    pulse(TX_START);
    pulse(RX_SECOND_BYTE);
    LOG_RSSI_I = 4'h1;
    step(2);
    check(RSSI_READOUT, 8'h95);
    pulse(TX_START);
    check(RSSI_READOUT, 8'h00);
    $display("TB: rssi test done");
    {COLLISION_THRESHOLD, RSSI_ENV} = 8'h31;
    u_host.command(1);
    check(MON_ENABLED, 1'b1);
    pulse(TX_START);
    pulse(RX_BIT_STROBE);
    step(5);
    pulse(RX_BIT_STROBE);
    RSSI_ENV = 4'h7;
    pulse(RX_BIT_STROBE);
    RSSI_ENV = 4'h1;
    pulse(RX_PILOT_END);
    pulse(RX_DATA_START);
    pulse(RX_PROTO_ERROR);
    pulse(RX_END);
    step(1);
    check(COLLISION_FLAG, 1'b1);
    check(MON_TIME.first_cross, 12'h002);
    check(MON_TIME.cross_len, 12'h001);
    check(MON_TIME.first_viol, 12'h003);
    check(MON_RSSI, 24'h01_0107);
    u_host.command(2);
    check({MON_ENABLED, |{MON_RSSI, MON_TIME}}, 2'h0);
    $display("TB: monitor test done");
    conclude();
  end
endmodule
